/* File: rtl/gpio_port_pkg.sv */
package gpio_port_pkg;

    // Register indices; the byte address on the bus is four times the index.
    localparam logic [15:0] IDX_LATCH = 16'hFE68;
    localparam logic [15:0] IDX_DIR = 16'hFE69;
    localparam logic [15:0] IDX_LATCH_RAW = 16'hFE6A;
    localparam logic [15:0] IDX_FSEL = 16'hFE6B;

    // Reset values of the three software registers.
    localparam logic [7:0] RST_LATCH = 8'h00;
    localparam logic [7:0] RST_DIR = 8'h00;
    localparam logic [7:0] RST_FSEL = 8'h00;

    // Pins that the two PWM channels may reach.
    localparam logic [7:0] FIRST_PWM_BITS = 8'h0F;
    localparam logic [7:0] SECOND_PWM_BITS = 8'hF0;

    // Drive state of all eight pins: level, enable and pull-up.
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
        logic [7:0] pull;
    } pin_drive_t;

    // Complete state of the port.
    typedef struct packed {
        logic [7:0] latch;
        logic [7:0] dir;
        logic [7:0] fsel;
        logic [7:0] sync1;
        logic [7:0] sync2;
        logic [31:0] prdata;
        logic pslverr;
        logic hold;
        pin_drive_t snap;
    } port_state_t;

    // Byte address of a register from its index.
    function automatic logic [31:0] reg_addr(input logic [15:0] idx);
        return {14'h0000, idx, 2'b00};
    endfunction : reg_addr

endpackage : gpio_port_pkg

/* File: rtl/eight_bit_port_with_pwm_mux.sv */
// Register access over APB was left to the implementer.
module eight_bit_port_with_pwm_mux #(
    parameter logic [7:0] OPEN_DRAIN = 8'h00
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic low_power,
    input wire logic first_pwm_channel,
    input wire logic second_pwm_channel,
    input wire logic [7:0] pin_in,
    output logic [7:0] pin_out,
    output logic [7:0] pin_oe,
    output logic [7:0] pullup_en
);
    import gpio_port_pkg::*;

    // Registered state and its next value.
    port_state_t s;
    port_state_t next_s;

    // Drive computed from the live registers and PWM inputs.
    pin_drive_t live;

    // Drive that actually reaches the pins.
    pin_drive_t drive;

    // Setup cycle of any bus transfer.
    logic setup_phase;

    // Completing write access.
    logic write_access;

    // Address that none of the four register words decodes.
    logic unmapped;

    // Works out the per-pin drive from the registers and PWM levels.
    function automatic pin_drive_t compute_drive(
        input logic [7:0] latch,
        input logic [7:0] dir,
        input logic [7:0] fsel,
        input logic pwm_a,
        input logic pwm_b,
        input logic [7:0] od
    );
        pin_drive_t d;
        logic [7:0] pwm_bits;
        logic [7:0] level;
        pwm_bits = (FIRST_PWM_BITS & {8{pwm_a}}) | (SECOND_PWM_BITS & {8{pwm_b}});
        level = (fsel & (latch | pwm_bits)) | (~fsel & latch);
        d.out = level;
        d.oe = dir & (~level | ~od);
        d.pull = ~dir & latch;
        return d;
    endfunction : compute_drive

    // The live drive follows PWM at once, so no flip-flop sits in its path.
    always_comb begin
        live = compute_drive(s.latch, s.dir, s.fsel, first_pwm_channel,
                             second_pwm_channel, OPEN_DRAIN);
        drive = s.hold ? s.snap : live;
    end

    // Pin outputs; open-drain bits never enable a high level.
    assign pin_out = drive.out;
    assign pin_oe = drive.oe;
    assign pullup_en = drive.pull;

    // The slave never inserts wait states.
    assign pready = 1'b1;
    assign prdata = s.prdata;
    assign pslverr = s.pslverr;

    assign setup_phase = psel & ~penable;
    assign write_access = psel & penable & pwrite;

    // Kept apart from the decode chain so the checks can name the error case directly.
    assign unmapped = (paddr != reg_addr(IDX_LATCH)) && (paddr != reg_addr(IDX_LATCH_RAW))
        && (paddr != reg_addr(IDX_DIR)) && (paddr != reg_addr(IDX_FSEL));

    // Next-state logic: bus decode, synchroniser and low-power snapshot.
    always_comb begin
        next_s = s;
        // Pins are asynchronous, so two flops stand before any reader.
        next_s.sync1 = pin_in;
        next_s.sync2 = s.sync1;
        // Read data and error are prepared in the setup cycle.
        if (setup_phase) begin
            next_s.prdata = 32'h0000_0000;
            next_s.pslverr = 1'b0;
            if (paddr == reg_addr(IDX_LATCH)) begin
                // A plain read returns the pins whatever their direction.
                next_s.prdata[7:0] = s.sync2;
            end else if (paddr == reg_addr(IDX_LATCH_RAW)) begin
                // Read-modify-write sequences start from the stored latch.
                next_s.prdata[7:0] = s.latch;
            end else if (paddr == reg_addr(IDX_DIR)) begin
                next_s.prdata[7:0] = s.dir;
            end else if (paddr == reg_addr(IDX_FSEL)) begin
                next_s.prdata[7:0] = s.fsel;
            end else begin
                // Unmapped address answers with an error and zero data.
                next_s.pslverr = 1'b1;
            end
        end
        // Writes take effect only at the access edge.
        if (write_access) begin
            if (paddr == reg_addr(IDX_LATCH) || paddr == reg_addr(IDX_LATCH_RAW)) begin
                next_s.latch = pwdata[7:0];
            end else if (paddr == reg_addr(IDX_DIR)) begin
                next_s.dir = pwdata[7:0];
            end else if (paddr == reg_addr(IDX_FSEL)) begin
                next_s.fsel = pwdata[7:0];
            end
        end
        // Entering low power captures the drive seen just before entry.
        next_s.hold = low_power;
        if (low_power && !s.hold) begin
            next_s.snap = live;
        end
    end

    // State register; every flop takes a constant under reset.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s.latch <= RST_LATCH;
            s.dir <= RST_DIR;
            s.fsel <= RST_FSEL;
            s.sync1 <= 8'h00;
            s.sync2 <= 8'h00;
            s.prdata <= 32'h0000_0000;
            s.pslverr <= 1'b0;
            s.hold <= 1'b0;
            s.snap <= '0;
        end else begin
            s <= next_s;
        end
    end

    // Checks of the port behaviour.
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // An input bit never drives while low power is off.
    property p_input_not_driven;
        !s.hold |-> ((~s.dir & pin_oe) == 8'h00);
    endproperty
    a_input_not_driven: assert property (p_input_not_driven)
        else $error("input pin is driven");

    // Pull-up exactly on input bits with latch one.
    property p_pullup;
        !s.hold |-> (pullup_en == (~s.dir & s.latch));
    endproperty
    a_pullup: assert property (p_pullup)
        else $error("pull-up state wrong");

    // Output with latch zero and plain function drives low.
    property p_low_drive;
        !s.hold |-> (((s.dir & ~s.fsel & ~s.latch) & ~(pin_oe & ~pin_out)) == 8'h00);
    endproperty
    a_low_drive: assert property (p_low_drive)
        else $error("output low not driven");

    // Open-drain bits never drive high.
    property p_open_drain;
        (pin_oe & pin_out & OPEN_DRAIN) == 8'h00;
    endproperty
    a_open_drain: assert property (p_open_drain)
        else $error("open-drain bit driven high");

    // PWM bits carry their channel in the same cycle.
    property p_pwm_route;
        !s.hold |-> ((pin_out & s.dir & s.fsel & ~s.latch) == (s.dir & s.fsel & ~s.latch
            & ((FIRST_PWM_BITS & {8{first_pwm_channel}})
            | (SECOND_PWM_BITS & {8{second_pwm_channel}}))));
    endproperty
    a_pwm_route: assert property (p_pwm_route)
        else $error("PWM routing wrong");

    // Function select with latch one forces a high level.
    property p_forced_high;
        !s.hold |-> ((s.dir & s.fsel & s.latch & ~pin_out) == 8'h00);
    endproperty
    a_forced_high: assert property (p_forced_high)
        else $error("forced high missing");

    // A plain latch read returns the synchronised pin levels.
    property p_read_pins;
        (setup_phase && paddr == reg_addr(IDX_LATCH))
            |=> (prdata == {24'h000000, $past(s.sync2)}) && pready && !pslverr;
    endproperty
    a_read_pins: assert property (p_read_pins)
        else $error("latch read not pin levels");

    // The raw read returns the stored latch.
    property p_read_raw;
        (setup_phase && paddr == reg_addr(IDX_LATCH_RAW))
            |=> (prdata == {24'h000000, $past(s.latch)});
    endproperty
    a_read_raw: assert property (p_read_raw)
        else $error("raw latch read wrong");

    // A direction write lands in the direction register.
    property p_dir_write;
        (write_access && paddr == reg_addr(IDX_DIR)) |=> (s.dir == $past(pwdata[7:0]));
    endproperty
    a_dir_write: assert property (p_dir_write)
        else $error("direction write lost");

    // Pins stay frozen while low power lasts.
    property p_hold_frozen;
        (s.hold && $past(s.hold)) |-> ($stable(pin_oe) && $stable(pin_out) && $stable(pullup_en));
    endproperty
    a_hold_frozen: assert property (p_hold_frozen)
        else $error("pins changed in low power");

    // The first frozen cycle shows the drive of the cycle before entry.
    property p_freeze_entry;
        (s.hold && !$past(s.hold)) |-> ({pin_out, pin_oe, pullup_en} == $past(live));
    endproperty
    a_freeze_entry: assert property (p_freeze_entry)
        else $error("frozen drive not the entry drive");

    // A push-pull output with latch one and plain function drives high.
    property p_push_pull_high;
        !s.hold |-> (((s.dir & ~s.fsel & s.latch & ~OPEN_DRAIN) & ~(pin_oe & pin_out)) == 8'h00);
    endproperty
    a_push_pull_high: assert property (p_push_pull_high)
        else $error("push-pull high not driven");

    // A write to either latch word lands in the latch.
    property p_latch_write;
        (write_access && (paddr == reg_addr(IDX_LATCH) || paddr == reg_addr(IDX_LATCH_RAW)))
            |=> (s.latch == $past(pwdata[7:0]));
    endproperty
    a_latch_write: assert property (p_latch_write)
        else $error("latch write lost");

    // The direction word reads back the stored direction.
    property p_read_dir;
        (setup_phase && paddr == reg_addr(IDX_DIR))
            |=> (prdata == {24'h000000, $past(s.dir)}) && !pslverr;
    endproperty
    a_read_dir: assert property (p_read_dir)
        else $error("direction read wrong");

    // Only the decoded words answer; any other address reports an error with zero data.
    property p_unmapped_error;
        (setup_phase && unmapped) |=> pslverr && (prdata == 32'h0000_0000);
    endproperty
    a_unmapped_error: assert property (p_unmapped_error)
        else $error("unmapped access not refused");

    // A write to an unmapped address leaves every register as it was.
    property p_unmapped_ignored;
        (write_access && unmapped) |=> $stable(s.latch) && $stable(s.dir) && $stable(s.fsel);
    endproperty
    a_unmapped_ignored: assert property (p_unmapped_ignored)
        else $error("unmapped write changed a register");

    // Main scenarios.
    property p_cov_pwm;
        !s.hold && ((s.dir & s.fsel & ~s.latch) != 8'h00);
    endproperty
    c_cov_pwm: cover property (p_cov_pwm);

    property p_cov_hold;
        low_power && !s.hold ##1 s.hold [*3];
    endproperty
    c_cov_hold: cover property (p_cov_hold);

    property p_cov_error;
        psel && penable && pslverr;
    endproperty
    c_cov_error: cover property (p_cov_error);

    property p_cov_forced_high;
        !s.hold && ((s.dir & s.fsel & s.latch) != 8'h00);
    endproperty
    c_cov_forced_high: cover property (p_cov_forced_high);

    property p_cov_raw_write;
        write_access && (paddr == reg_addr(IDX_LATCH_RAW));
    endproperty
    c_cov_raw_write: cover property (p_cov_raw_write);

endmodule : eight_bit_port_with_pwm_mux

/* File: tb/pin_board.sv */
module pin_board (
    input wire logic pclk,
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] pullup_en,
    input wire logic [7:0] ext_oe,
    input wire logic [7:0] ext_val,
    output logic [7:0] pin_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] drift = 8'h5A; // Level seen on a wire that nobody holds.

    // A floating wire must not repeat its last level, so it flips each cycle.
    always_ff @(posedge pclk) begin
        drift <= ~drift;
    end

    // The device wins over the board, the board over the weak pull-up.
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (pin_oe[i]) begin
                pin_in[i] = pin_out[i];
            end else if (ext_oe[i]) begin
                pin_in[i] = ext_val[i];
            end else begin
                pin_in[i] = pullup_en[i] | drift[i];
            end
        end
    end
endmodule : pin_board

/* File: tb/eight_bit_port_with_pwm_mux_test.sv */
module eight_bit_port_with_pwm_mux_test;
    timeunit 1ns;
    timeprecision 1ps;
    import gpio_port_pkg::*;
    localparam logic [7:0] OD = 8'hC3; // Open-drain bits of this build.
    logic pclk, presetn, psel, penable, pwrite, low_power, pwm_a, pwm_b, pready, pslverr;
    logic [31:0] paddr, pwdata, prdata;
    logic [7:0] pin_in, pin_out, pin_oe, pullup_en, ext_oe, ext_val, r_l, r_d, r_f;
    logic [23:0] e24;
    logic [32:0] expq[$]; // Expected error flag and read data, oldest first.
    int n_fail = 0;
    int tests_run = 0;
    logic [31:0] seed = 32'h0000000E; // Fixed start keeps runs repeatable.

    eight_bit_port_with_pwm_mux #(.OPEN_DRAIN(OD)) dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .low_power(low_power),
        .first_pwm_channel(pwm_a), .second_pwm_channel(pwm_b), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .pullup_en(pullup_en));
    pin_board board (.pclk(pclk), .pin_out(pin_out), .pin_oe(pin_oe),
        .pullup_en(pullup_en), .ext_oe(ext_oe), .ext_val(ext_val), .pin_in(pin_in));

    // Clock generator.
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction : rnd

    // Expected driven level, enable and pull-up from latch, direction, select.
    function automatic logic [23:0] expd(input logic [7:0] l, d, f);
        logic [7:0] lv, oe;
        for (int i = 0; i < 8; i++) begin
            lv[i] = f[i] ? (l[i] | (i < 4 ? pwm_a : pwm_b)) : l[i];
        end
        oe = d & (~lv | ~OD);
        return {lv & oe, oe, ~d & l};
    endfunction : expd

    task automatic check(input string what, input logic [32:0] e, input logic [32:0] g);
        tests_run++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, e, g);
        end
    endtask : check

    // One APB transfer; the request holds until pready is seen high.
    task automatic apb(input logic w, input logic [15:0] idx, input logic [7:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {14'h0000, idx, 2'b00};
        pwdata <= {24'hA5A5A5, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        // One idle edge, so a following call never reassigns psel in this time step.
        @(posedge pclk);
    endtask : apb

    task automatic rd(input logic [15:0] idx, input logic [7:0] e, input logic err);
        expq.push_back({err, 24'h000000, e});
        apb(1'b0, idx, 8'h00);
    endtask : rd

    task automatic cfg(input logic [7:0] l, d, f);
        apb(1'b1, IDX_LATCH, l);
        apb(1'b1, IDX_DIR, d);
        apb(1'b1, IDX_FSEL, f);
    endtask : cfg

    // Pins are looked at mid-cycle, where the combinational drive has settled.
    task automatic chk_pins(input logic [7:0] l, d, f);
        @(negedge pclk);
        check("pins", expd(l, d, f), {pin_out & pin_oe, pin_oe, pullup_en});
        @(posedge pclk);
    endtask : chk_pins

    task automatic test_done();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : test_done

    // Each completed read is compared with the oldest note.
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite) begin
            // A read with no note expects a value the port can never return.
            check("read", (expq.size() > 0) ? expq.pop_front() : 33'h1_FFFF_FFFF, {pslverr, prdata});
        end
    end

    // Watchdog: the sequence needs well under a thousand cycles.
    initial begin
        #20000;
        n_fail++;
        test_done();
    end

    initial begin
        {presetn, psel, penable, pwrite, low_power, pwm_a, pwm_b} = 7'h00;
        paddr = 32'h00000000;
        pwdata = 32'h00000000;
        ext_oe = 8'hFF;
        ext_val = 8'h3C;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(IDX_DIR, RST_DIR, 1'b0);
        rd(IDX_FSEL, RST_FSEL, 1'b0);
        rd(IDX_LATCH_RAW, RST_LATCH, 1'b0);
        rd(IDX_LATCH, 8'h3C, 1'b0);
        apb(1'b1, 16'hFE6C, 8'hFF);
        rd(16'hFE6C, 8'h00, 1'b1);
        rd(IDX_DIR, 8'h00, 1'b0);
        apb(1'b1, IDX_LATCH_RAW, 8'h5A);
        rd(IDX_LATCH_RAW, 8'h5A, 1'b0);
        $display("test reset and unmapped done");
        ext_oe <= 8'h00;
        cfg(8'hFF, 8'h00, 8'h00);
        chk_pins(8'hFF, 8'h00, 8'h00);
        repeat (3) @(posedge pclk);
        rd(IDX_LATCH, 8'hFF, 1'b0);
        $display("test pull-up done");
        for (int k = 0; k < 8; k++) begin
            r_l = rnd();
            r_d = rnd();
            r_f = rnd();
            pwm_a <= seed[9];
            pwm_b <= seed[17];
            ext_val <= rnd();
            cfg(r_l, r_d, r_f);
            chk_pins(r_l, r_d, r_f);
            pwm_a <= ~pwm_a;
            pwm_b <= ~pwm_b;
            chk_pins(r_l, r_d, r_f);
            e24 = expd(r_l, r_d, r_f);
            ext_oe <= ~e24[15:8];
            repeat (3) @(posedge pclk);
            rd(IDX_LATCH, e24[23:16] | (ext_val & ~e24[15:8]), 1'b0);
            rd(IDX_LATCH_RAW, r_l, 1'b0);
            rd(IDX_DIR, r_d, 1'b0);
        end
        $display("test random drive done");
        ext_oe <= 8'h00;
        cfg(8'h0F, 8'hFF, 8'h00);
        chk_pins(8'h0F, 8'hFF, 8'h00);
        low_power <= 1'b1;
        @(posedge pclk);
        apb(1'b1, IDX_LATCH, 8'hF0);
        chk_pins(8'h0F, 8'hFF, 8'h00);
        low_power <= 1'b0;
        @(posedge pclk);
        chk_pins(8'hF0, 8'hFF, 8'h00);
        $display("test low power done");
        repeat (2) @(posedge pclk);
        test_done();
    end
endmodule : eight_bit_port_with_pwm_mux_test
